/* inc/cps_pkg.sv */
// Package for the card power switch control block: offsets, fields, types
package cps_pkg;

    // ==========================================================
    // Register map (byte addresses on the plain register port)
    localparam logic [11:0] ADDR_SW_ONE = 12'h080E;
    localparam logic [11:0] ADDR_SW_TWO = 12'h080F;
    localparam logic [11:0] ADDR_VAR = 12'h0811;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0812;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h0813;
    localparam logic [11:0] ADDR_PULL_CTL = 12'h0814;
    localparam logic [11:0] ADDR_PIN_STATE = 12'h0815;

    // ==========================================================
    // Field positions
    localparam int SW_FUNC_BIT = 5;
    localparam int SW_ON_BIT = 4;
    localparam int VAR_LEVEL_BIT = 6;
    localparam int VAR_TUNE_BIT = 5;
    localparam int VAR_ON_BIT = 4;

    // Writable masks; reserved bits read zero and ignore writes
    localparam logic [7:0] SW_WMASK = 8'h3F;
    localparam logic [7:0] VAR_WMASK = 8'h70;
    localparam logic [7:0] IRQ_WMASK = 8'h07;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SW_RESET = 8'h20;
    localparam logic [7:0] VAR_RESET = 8'h00;
    localparam logic [3:0] MODE_200MA = 4'h0;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int TUNE_MIN_NS = 500;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int TUNE_MIN_CYC = (TUNE_MIN_NS + CLK_NS - 1) / CLK_NS;

    // One sense pin's pad controls
    typedef struct packed {
        logic oe_n;   // Output enable, low drives
        logic ie;     // Input buffer enable
        logic pu;     // Pull-up
        logic pd;     // Pull-down
    } cps_pad_t;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cps_req_t;

endpackage

/* core/cps_pin_ctl.sv */
// One shared sense pin: pad enable override and falling-edge event
`timescale 1ns/1ps
`default_nettype none
module cps_pin_ctl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic card_mode,
    input wire logic supply_on,
    input wire logic gp_oe_n,
    input wire logic gp_ie,
    input wire logic pull_up,
    input wire logic pull_down,
    input wire logic pin_in,
    output cps_pkg::cps_pad_t pad,
    output logic fall_pulse
);
    import cps_pkg::*;

    logic level_q;
    logic armed_q;

    // Pad enables: card mode forces input only, buffer follows supply
    always_comb begin
        if (card_mode) begin
            pad.oe_n = 1'b1;
            pad.ie = supply_on;
        end else begin
            pad.oe_n = gp_oe_n;
            pad.ie = gp_ie;
        end
        pad.pu = pull_up;
        pad.pd = pull_down;
    end

    // Falling edge seen only while the buffer is live
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            level_q <= pin_in & pad.ie;
            armed_q <= pad.ie;
        end
    end

    assign fall_pulse = armed_q & pad.ie & level_q & ~pin_in;

endmodule
`default_nettype wire

/* core/cps_ctl.sv */
// Card power switch control registers, pad overrides and short interrupt
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Switch registers reset to 0x20: card mode, supply off, 200 mA mode.
// - Card mode: pin is input; buffer off while supply off, on when on.
// - No pull applied on sense pin unless firmware enables one.
// - Function select 0: plain pin use, supply on held at zero.
// - Function select 1: pin output driver forced off, input buffer follows supply on.
// - Supply on bit 4 switches; reads zero, writes dropped, in pin mode.
// - Current mode bits 3:0 default 0000 (200 mA); others reserved.
// - Firmware arms falling edge; device interrupts when pin drops.
// - Variable supply register resets to 0x00, pin in card mode.
// - Level bit 6: 0 gives 3.0V, 1 gives 1.8V.
// - Regulator on bit 4; while on, pin output driver disabled.
// - Each supply uses its shared pin as overcurrent sense input.
module cps_ctl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire cps_pkg::cps_req_t req,
    output logic [7:0] rdata,
    input wire logic [2:0] pin_in,
    input wire logic [2:0] gp_oe_n,
    input wire logic [2:0] gp_ie,
    output cps_pkg::cps_pad_t pad_one,
    output cps_pkg::cps_pad_t pad_two,
    output cps_pkg::cps_pad_t pad_var,
    output logic switch_one_on,
    output logic switch_two_on,
    output logic var_on,
    output logic var_level_low,
    output logic var_tune,
    output logic var_tune_done,
    output logic [3:0] switch_one_mode,
    output logic [3:0] switch_two_mode,
    output logic irq
);
    import cps_pkg::*;

    logic [7:0] sw_q [2];
    logic [7:0] var_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;
    logic [5:0] pull_q;
    logic [7:0] rdata_q;
    logic [7:0] tune_cnt_q;
    logic [2:0] fall;
    logic [2:0] card_mode;
    logic [2:0] on_bits;
    cps_pad_t pads [3];

    // Next switch register value after a write, function select enforced
    function automatic logic [7:0] sw_next(input logic [7:0] wd);
        logic [7:0] v;
        v = wd & SW_WMASK;
        if (!v[SW_FUNC_BIT]) begin
            v[SW_ON_BIT] = 1'b0;
        end
        return v;
    endfunction

    // ==========================================================
    // Registers

    // Fixed switch control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw_q[0] <= SW_RESET;
            sw_q[1] <= SW_RESET;
        end else if (req.wr) begin
            if (req.addr == ADDR_SW_ONE) begin
                sw_q[0] <= sw_next(req.wdata);
            end
            if (req.addr == ADDR_SW_TWO) begin
                sw_q[1] <= sw_next(req.wdata);
            end
        end
    end

    // Variable supply control register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            var_q <= VAR_RESET;
        end else if (req.wr && req.addr == ADDR_VAR) begin
            var_q <= req.wdata & VAR_WMASK;
        end
    end

    // Pull controls: pairs of up/down per pin, off after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pull_q <= 6'h00;
        end else if (req.wr && req.addr == ADDR_PULL_CTL) begin
            pull_q <= req.wdata[5:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_mask_q <= 8'h00;
        end else if (req.wr && req.addr == ADDR_IRQ_MASK) begin
            irq_mask_q <= req.wdata & IRQ_WMASK;
        end
    end

    // Sticky status: write one clears, a new event wins over the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_q <= 8'h00;
        end else begin
            if (req.wr && req.addr == ADDR_IRQ_STATUS) begin
                irq_stat_q <= (irq_stat_q & ~req.wdata) | {5'h00, fall};
            end else begin
                irq_stat_q <= irq_stat_q | {5'h00, fall};
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Tune hold timer: counts cycles the tune bit has stood
    always_ff @(posedge clk) begin
        if (sys_rst || !var_q[VAR_TUNE_BIT]) begin
            tune_cnt_q <= 8'h00;
        end else if (tune_cnt_q < 8'(TUNE_MIN_CYC)) begin
            tune_cnt_q <= tune_cnt_q + 8'h01;
        end
    end

    assign var_tune_done = (tune_cnt_q >= 8'(TUNE_MIN_CYC));

    // ==========================================================
    // Read port

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (sys_rst || !req.rd) begin
            rdata_q <= 8'h00;
        end else begin
            case (req.addr)
                ADDR_SW_ONE: rdata_q <= sw_q[0];
                ADDR_SW_TWO: rdata_q <= sw_q[1];
                ADDR_VAR: rdata_q <= var_q;
                ADDR_IRQ_STATUS: rdata_q <= irq_stat_q;
                ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
                ADDR_PULL_CTL: rdata_q <= {2'b00, pull_q};
                ADDR_PIN_STATE: rdata_q <= {5'h00, pin_in};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata = rdata_q;

    // ==========================================================
    // Supply outputs and pin control

    assign card_mode = {1'b1, sw_q[1][SW_FUNC_BIT], sw_q[0][SW_FUNC_BIT]};
    assign on_bits = {var_q[VAR_ON_BIT], sw_q[1][SW_ON_BIT],
                      sw_q[0][SW_ON_BIT]};

    assign switch_one_on = sw_q[0][SW_ON_BIT];
    assign switch_two_on = sw_q[1][SW_ON_BIT];
    assign var_on = var_q[VAR_ON_BIT];
    assign var_level_low = var_q[VAR_LEVEL_BIT];
    assign var_tune = var_q[VAR_TUNE_BIT];
    assign switch_one_mode = sw_q[0][3:0];
    assign switch_two_mode = sw_q[1][3:0];

    // One pad controller per shared sense pin
    for (genvar i = 0; i < 3; i++) begin : g_pin
        cps_pin_ctl u_pin (
            .clk(clk),
            .sys_rst(sys_rst),
            .card_mode(card_mode[i]),
            .supply_on(on_bits[i]),
            .gp_oe_n(gp_oe_n[i]),
            .gp_ie(gp_ie[i]),
            .pull_up(pull_q[2*i]),
            .pull_down(pull_q[2*i+1]),
            .pin_in(pin_in[i]),
            .pad(pads[i]),
            .fall_pulse(fall[i])
        );
    end

    assign pad_one = pads[0];
    assign pad_two = pads[1];
    assign pad_var = pads[2];

    // ==========================================================
    // Checks

    // Writes that select plain pin use, and a full thirteen cycle tune hold
    sequence s_sw_one_write_pin;
        req.wr && req.addr == ADDR_SW_ONE && !req.wdata[SW_FUNC_BIT];
    endsequence

    sequence s_sw_two_write_pin;
        req.wr && req.addr == ADDR_SW_TWO && !req.wdata[SW_FUNC_BIT];
    endsequence

    sequence s_tune_held;
        $rose(var_tune) ##1 var_tune [*8] ##1 var_tune [*4];
    endsequence

    // Pin use written on switch one drops its supply bit
    a_pin_mode_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_sw_one_write_pin |=> !switch_one_on)
        else $error("supply on set in pin mode");

    // Pin use written on switch two drops its supply bit
    a_pin_two_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_sw_two_write_pin |=> !switch_two_on)
        else $error("supply two on set in pin mode");

    // Supply bit stays zero in plain pin use
    a_pin_mode_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!sw_q[0][SW_FUNC_BIT] |-> !sw_q[0][SW_ON_BIT]) and
        (!sw_q[1][SW_FUNC_BIT] |-> !sw_q[1][SW_ON_BIT]))
        else $error("supply bit not held zero");

    // Plain pin use passes the pin's own output enable through
    a_pin_oe_pass: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!sw_q[0][SW_FUNC_BIT] |-> pad_one.oe_n == gp_oe_n[0]) and
        (!sw_q[1][SW_FUNC_BIT] |-> pad_two.oe_n == gp_oe_n[1]))
        else $error("pin output enable not passed");

    // Card use forces the output driver off
    a_card_oe_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sw_q[0][SW_FUNC_BIT] |-> pad_one.oe_n) and
        (sw_q[1][SW_FUNC_BIT] |-> pad_two.oe_n))
        else $error("driver on in card mode");

    // Input buffer of a fixed switch pin follows its supply in card use
    a_buffer_follows: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sw_q[0][SW_FUNC_BIT] |-> pad_one.ie == switch_one_on) and
        (sw_q[1][SW_FUNC_BIT] |-> pad_two.ie == switch_two_on))
        else $error("input buffer wrong");

    // Variable supply pin is a sense input live only with the supply
    a_var_buffer: assert property (
        @(posedge clk) disable iff (sys_rst)
        pad_var.ie == var_on)
        else $error("variable pin buffer wrong");

    // No pin output driver while the regulator is on
    a_var_oe_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        var_on |-> pad_var.oe_n)
        else $error("driver on while regulator on");

    // Regulator enable follows the last write
    a_supply_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        req.wr && req.addr == ADDR_VAR |=>
        var_on == $past(req.wdata[VAR_ON_BIT]))
        else $error("regulator enable not written");

    // Level select follows the last write
    a_level_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        req.wr && req.addr == ADDR_VAR |=>
        var_level_low == $past(req.wdata[VAR_LEVEL_BIT]))
        else $error("level select not written");

    // Switch registers come out of reset in card use, supply off
    a_reset_value: assert property (
        @(posedge clk)
        sys_rst |=> sw_q[0] == SW_RESET && sw_q[1] == SW_RESET)
        else $error("bad switch reset value");

    // Variable supply register comes out of reset cleared
    a_var_reset: assert property (
        @(posedge clk)
        sys_rst |=> var_q == VAR_RESET)
        else $error("bad regulator reset value");

    // Current mode fields come out of reset at the 200 mA code
    a_mode_reset: assert property (
        @(posedge clk)
        sys_rst |=> switch_one_mode == MODE_200MA &&
        switch_two_mode == MODE_200MA)
        else $error("bad current mode after reset");

    // Reserved bits never set
    a_reserved_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        var_q[7] == 1'b0 && var_q[3:0] == 4'h0 &&
        sw_q[0][7:6] == 2'b00 && sw_q[1][7:6] == 2'b00)
        else $error("reserved bit set");

    // No pull on any sense pin unless firmware asked for one
    a_no_pull: assert property (
        @(posedge clk) disable iff (sys_rst)
        pull_q == 6'h00 |-> !pad_one.pu && !pad_one.pd &&
        !pad_two.pu && !pad_two.pd && !pad_var.pu && !pad_var.pd)
        else $error("pull applied");

    // Every falling edge lands in the sticky status
    a_fall_status: assert property (
        @(posedge clk) disable iff (sys_rst)
        fall != 3'b000 |=> (irq_stat_q[2:0] & $past(fall)) == $past(fall))
        else $error("short not recorded");

    // An unmasked edge raises the interrupt in the next cycle
    a_fall_irq: assert property (
        @(posedge clk) disable iff (sys_rst)
        (fall & irq_mask_q[2:0]) != 3'b000 &&
        !(req.wr && req.addr == ADDR_IRQ_MASK) |=> irq)
        else $error("short not flagged");

    // Writing ones clears status bits when no edge competes
    a_status_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        req.wr && req.addr == ADDR_IRQ_STATUS && fall == 3'b000 |=>
        (irq_stat_q & $past(req.wdata)) == 8'h00)
        else $error("status not cleared");

    // Interrupt stays low with every source masked
    a_irq_quiet: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq_mask_q == 8'h00 |-> !irq)
        else $error("interrupt while masked");

    // Tune done never shows before thirteen cycles of hold
    a_tune_time: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(var_tune) |-> ##12 !var_tune_done)
        else $error("tune done too early");

    // Tune done shows once the full hold is complete
    a_tune_reached: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_tune_held |=> var_tune_done)
        else $error("tune done missing");

    // Tune done falls once the bit is cleared
    a_tune_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        !var_tune |=> !var_tune_done)
        else $error("tune done stuck");

endmodule
`default_nettype wire

/* verification/cps_card_model.sv */
// Card supply and overcurrent sense pin model for the card power bench
`timescale 1ns/1ps
`default_nettype none
module cps_card_model (
    input wire logic [2:0] supply_en,
    input wire logic [2:0] short_req,
    output logic [2:0] sense
);
    // Sense is high only while its supply is up and the card is not shorted
    assign sense = supply_en & ~short_req;
endmodule
`default_nettype wire

/* verification/test_cps_ctl.sv */
// Self-checking bench for the card power switch control registers
`timescale 1ns/1ps
`default_nettype none
module test_cps_ctl;
    import cps_pkg::*;
    logic clk, sys_rst;
    cps_req_t req;
    logic [7:0] rdata;
    logic [2:0] pin_in, gp_oe_n, gp_ie, short_q;
    cps_pad_t pad_one, pad_two, pad_var;
    logic sw1, sw2, von, vlow, vtune, vdone, irq;
    logic [3:0] m1, m2;
    int num_errors, n_checks;

    // ==========================================
    // Design and far side
    cps_ctl cps_ctl_inst (.clk(clk), .sys_rst(sys_rst), .req(req),
        .rdata(rdata), .pin_in(pin_in), .gp_oe_n(gp_oe_n), .gp_ie(gp_ie),
        .pad_one(pad_one), .pad_two(pad_two), .pad_var(pad_var),
        .switch_one_on(sw1), .switch_two_on(sw2), .var_on(von),
        .var_level_low(vlow), .var_tune(vtune), .var_tune_done(vdone),
        .switch_one_mode(m1), .switch_two_mode(m2), .irq(irq));
    cps_card_model cps_card_model_inst (.supply_en({von, sw2, sw1}),
        .short_req(short_q), .sense(pin_in));

    // ==========================================
    // Clock, compares and bus tasks
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk8(rdata, e);
    endtask
    task automatic end_sim();
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(ADDR_SW_ONE, 8'h20);
        rd(ADDR_SW_TWO, 8'h20);
        rd(ADDR_VAR, 8'h00);
        chk1(pad_one.ie, 1'b0);
        chk1(pad_var.ie, 1'b0);
        chk1(pad_one.oe_n, 1'b1);
        chk8({m2, m1}, 8'h00);
        chk8({6'h00, pad_one.pu, pad_one.pd}, 8'h00);
        chk8({6'h00, pad_two.pu, pad_two.pd}, 8'h00);
        chk8({6'h00, pad_var.pu, pad_var.pd}, 8'h00);
    endtask
    task automatic t_switch();
        wr(ADDR_SW_ONE, 8'h30);
        chk1(sw1, 1'b1);
        chk1(pad_one.ie, 1'b1);
        chk1(pad_one.oe_n, 1'b1);
        rd(ADDR_PIN_STATE, 8'h01);
        wr(ADDR_SW_ONE, 8'hF0);
        rd(ADDR_SW_ONE, 8'h30);
        chk8({4'h0, m1}, 8'h00);
        wr(ADDR_SW_ONE, 8'h10);
        rd(ADDR_SW_ONE, 8'h00);
        chk1(sw1, 1'b0);
        chk1(pad_one.oe_n, 1'b0);
        chk1(pad_one.ie, 1'b1);
        wr(ADDR_SW_TWO, 8'h10);
        rd(ADDR_SW_TWO, 8'h00);
        chk1(sw2, 1'b0);
        wr(ADDR_SW_TWO, 8'h30);
        rd(ADDR_SW_TWO, 8'h30);
        chk1(sw2, 1'b1);
        chk8({4'h0, m2}, 8'h00);
        chk1(pad_two.oe_n, 1'b1);
        chk1(pad_two.ie, 1'b1);
        wr(ADDR_SW_ONE, 8'h20);
    endtask
    task automatic t_var();
        wr(ADDR_VAR, 8'h40);
        chk1(vlow, 1'b1);
        chk1(pad_var.ie, 1'b0);
        wr(ADDR_VAR, 8'h50);
        chk1(von, 1'b1);
        chk1(pad_var.oe_n, 1'b1);
        chk1(pad_var.ie, 1'b1);
        rd(ADDR_PIN_STATE, 8'h06);
        wr(ADDR_VAR, 8'h70);
        repeat (8) @(posedge clk);
        #1 chk1(vdone, 1'b0);
        repeat (8) @(posedge clk);
        #1 chk1(vdone, 1'b1);
        wr(ADDR_VAR, 8'hFF);
        rd(ADDR_VAR, 8'h70);
        wr(ADDR_VAR, 8'h10);
        chk1(vlow, 1'b0);
        chk1(vtune, 1'b0);
    endtask
    task automatic t_irq();
        wr(ADDR_PULL_CTL, 8'h21);
        chk1(pad_one.pu, 1'b1);
        chk1(pad_var.pd, 1'b1);
        wr(ADDR_PULL_CTL, 8'h00);
        wr(ADDR_IRQ_STATUS, 8'h07);
        rd(ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h04);
        rd(ADDR_IRQ_MASK, 8'h04);
        chk1(irq, 1'b0);
        @(posedge clk);
        short_q <= 3'b100;
        repeat (3) @(posedge clk);
        #1 chk1(irq, 1'b1);
        rd(ADDR_IRQ_STATUS, 8'h04);
        @(posedge clk);
        short_q <= 3'b110;
        repeat (3) @(posedge clk);
        rd(ADDR_IRQ_STATUS, 8'h06);
        wr(ADDR_IRQ_STATUS, 8'h04);
        chk1(irq, 1'b0);
        rd(ADDR_IRQ_STATUS, 8'h02);
        rd(12'h0900, 8'h00);
    endtask
    task automatic t_mid_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        short_q <= 3'b000;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk1(irq, 1'b0);
        chk1(sw2, 1'b0);
        chk1(pad_two.ie, 1'b0);
        chk1(pad_var.ie, 1'b0);
        rd(ADDR_SW_TWO, 8'h20);
        rd(ADDR_VAR, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h00);
        rd(ADDR_IRQ_MASK, 8'h00);
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        num_errors = 0;
        n_checks = 0;
        req = '0;
        gp_oe_n = 3'b000;
        gp_ie = 3'b111;
        short_q = 3'b000;
        sys_rst = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_switch();
        t_var();
        t_irq();
        t_mid_reset();
        end_sim();
    end
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
